// ===== hw/cbd_defs.svh
// Constants shared by the configuration bitstream decompressor
// Behaviour
// - Compressed configuration data is expanded on the fly and written to the cells word by word.
// - Expansion is offered under the parallel passive, active serial and passive serial schemes.
// - Data arriving on the boundary-scan path is never expanded and is taken as uncompressed.
// - Expanding a piece of data takes less time than a serial link needs to deliver the next one; a parallel passive link can land a word during a run.
// - Each device obeys its own compression setting, whatever the other devices in a chain do.
`ifndef CBD_DEFS_SVH
`define CBD_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CBD_MCLK_PERIOD_NS 20
`define CBD_PP_CLKS_PER_WORD 3'h4
`define CBD_SER_BITS_PER_WORD 4'h8

// ****************************************************************
// Token layout and reset values
// ****************************************************************
`define CBD_TOKEN_RUN_BIT 7
`define CBD_TOKEN_LIT_MSB 6
`define CBD_TOKEN_RUN_MSB 3
`define CBD_RUN_FILL 8'h00
`define CBD_WORD_RST 8'h00
`define CBD_RUN_MAX 16

`endif

// ===== hw/cbd_expander.sv
// Run-length expander between the word sampler and the cell write path
`include "cbd_defs.svh"
module cbd_expander
	import cbd_pkg::*;
(
	input wire logic mclk, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic restart, // Frame not active, back to token
	input wire logic bypass, // Expansion off
	input wire logic in_valid, // One-cycle word strobe
	input wire logic [7:0] in_data, // Received word
	output logic out_valid, // One-cycle cell write strobe
	output logic [7:0] out_data, // Cell write word
	output logic busy // Run in progress, cannot take a word
);

	cbd_exp_state_t s_ff;
	cbd_exp_state_t nxt_s;

	// ****************************************************************
	// Expansion
	// ****************************************************************
	always_comb begin
		nxt_s = s_ff;
		nxt_s.out_valid = 1'b0;
		if (restart) begin
			nxt_s.st = exp_token;
			nxt_s.count = 7'h00;
		end else if (bypass) begin
			if (in_valid) begin
				nxt_s.out_valid = 1'b1;
				nxt_s.out_data = in_data;
			end
		end else begin
			case (s_ff.st)
				exp_token: begin
					if (in_valid && in_data[`CBD_TOKEN_RUN_BIT]) begin
						nxt_s.out_valid = 1'b1;
						nxt_s.out_data = `CBD_RUN_FILL;
						nxt_s.count = {3'h0, in_data[`CBD_TOKEN_RUN_MSB:0]};
						if (in_data[`CBD_TOKEN_RUN_MSB:0] != 4'h0) begin
							nxt_s.st = exp_run;
						end
					end else if (in_valid) begin
						nxt_s.count = in_data[`CBD_TOKEN_LIT_MSB:0];
						nxt_s.st = exp_literal;
					end
				end
				exp_literal: begin
					if (in_valid) begin
						nxt_s.out_valid = 1'b1;
						nxt_s.out_data = in_data;
						if (s_ff.count == 7'h00) begin
							nxt_s.st = exp_token;
						end else begin
							nxt_s.count = s_ff.count - 7'h01;
						end
					end
				end
				exp_run: begin
					// Runs of up to 16 words end before the next serial word lands; a fast parallel passive link can land one mid-run
					nxt_s.out_valid = 1'b1;
					nxt_s.out_data = `CBD_RUN_FILL;
					nxt_s.count = s_ff.count - 7'h01;
					if (s_ff.count == 7'h01) begin
						nxt_s.st = exp_token;
					end
				end
				default: begin
					nxt_s.st = exp_token;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign out_valid = s_ff.out_valid;
	assign out_data = s_ff.out_data;
	assign busy = (s_ff.st == exp_run);

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_two_fill;
		out_valid && out_data == `CBD_RUN_FILL ##1 out_valid ##1 !out_valid;
	endsequence

	property p_run_two;
		@(posedge mclk) disable iff (rst)
		(!restart && !bypass && s_ff.st == exp_token && in_valid && in_data == 8'h81)
		##1 !restart |-> s_two_fill;
	endproperty
	a_run_two: assert property (p_run_two) else $error("run of two fill words wrong");

	property p_literal_copy;
		@(posedge mclk) disable iff (rst)
		(!restart && !bypass && s_ff.st == exp_literal && in_valid)
		|=> out_valid && out_data == $past(in_data);
	endproperty
	a_literal_copy: assert property (p_literal_copy) else $error("literal not copied");

	property p_run_bound;
		@(posedge mclk) disable iff (rst)
		$rose(busy) |-> ##[1:16] !busy;
	endproperty
	a_run_bound: assert property (p_run_bound) else $error("run lasted too long");

endmodule : cbd_expander

// ===== hw/cbd_pkg.sv
// Types of the configuration bitstream decompressor
package cbd_pkg;

	typedef enum logic [1:0] {
		active_serial_scheme = 2'b00,
		passive_serial_scheme = 2'b01,
		parallel_passive_scheme = 2'b10,
		boundary_scan_scheme = 2'b11
	} cbd_scheme_t;

	typedef enum logic [1:0] {
		exp_token = 2'b00,
		exp_literal = 2'b01,
		exp_run = 2'b10
	} cbd_exp_st_t;

	typedef struct packed {
		cbd_exp_st_t st;
		logic [6:0] count;
		logic out_valid;
		logic [7:0] out_data;
	} cbd_exp_state_t;

	typedef struct packed {
		logic cclk_s1;
		logic cclk_s2;
		logic cclk_s3;
		logic ser_s1;
		logic ser_s2;
		logic [7:0] par_s1;
		logic [7:0] par_s2;
		logic act_s1;
		logic act_s2;
		logic comp_s1;
		logic comp_s2;
		logic [1:0] sch_s1;
		logic [1:0] sch_s2;
		cbd_scheme_t scheme;
		logic bypass;
		logic [2:0] edge_cnt;
		logic [2:0] bit_cnt;
		logic [7:0] shreg;
		logic [7:0] word;
		logic word_vld;
		logic overrun;
	} cbd_top_state_t;

endpackage : cbd_pkg

// ===== hw/cbd_top.sv
// Configuration bitstream decompressor: link sampler, mode selection and expander
`include "cbd_defs.svh"
module cbd_top
	import cbd_pkg::*;
(
	input wire logic mclk, // System clock, 50 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic config_clock, // Link clock pin
	input wire logic serial_data, // Serial data pin, LSB first
	input wire logic [7:0] parallel_data, // Parallel passive data pins
	input wire logic [1:0] scheme_sel, // Configuration scheme straps
	input wire logic compress_en, // This device's compression setting
	input wire logic config_active, // High while a frame is being loaded
	output logic cell_wr_valid, // One-cycle cell write strobe
	output logic [7:0] cell_wr_data, // Cell write word
	output logic overrun // Word arrived during a run, sticky per frame
);

	cbd_top_state_t s_ff;
	cbd_top_state_t nxt_s;
	logic exp_busy;
	logic cclk_rise;
	logic word_take;
	logic [7:0] word_in;
	logic [7:0] ser_word;

	// ****************************************************************
	// Link edge and word assembly
	// ****************************************************************
	// Only the second and third stages are looked at, never the first
	assign cclk_rise = s_ff.cclk_s2 && !s_ff.cclk_s3 && s_ff.act_s2;
	assign ser_word = {s_ff.ser_s2, s_ff.shreg[7:1]};

	always_comb begin
		word_take = 1'b0;
		word_in = s_ff.par_s2;
		if (s_ff.scheme == parallel_passive_scheme) begin
			// Compressed words are held four clocks, so only the first edge counts
			word_take = cclk_rise && (s_ff.bypass || s_ff.edge_cnt == 3'h0);
		end else begin
			word_in = ser_word;
			word_take = cclk_rise && ({1'b0, s_ff.bit_cnt} == `CBD_SER_BITS_PER_WORD - 4'h1);
		end
	end

	always_comb begin
		nxt_s = s_ff;
		nxt_s.cclk_s1 = config_clock;
		nxt_s.cclk_s2 = s_ff.cclk_s1;
		nxt_s.cclk_s3 = s_ff.cclk_s2;
		nxt_s.ser_s1 = serial_data;
		nxt_s.ser_s2 = s_ff.ser_s1;
		nxt_s.par_s1 = parallel_data;
		nxt_s.par_s2 = s_ff.par_s1;
		nxt_s.act_s1 = config_active;
		nxt_s.act_s2 = s_ff.act_s1;
		nxt_s.comp_s1 = compress_en;
		nxt_s.comp_s2 = s_ff.comp_s1;
		nxt_s.sch_s1 = scheme_sel;
		nxt_s.sch_s2 = s_ff.sch_s1;
		nxt_s.word_vld = word_take;
		if (word_take) begin
			nxt_s.word = word_in;
		end
		if (!s_ff.act_s2) begin
			// Mode is frozen for the frame so a strap glitch cannot split a word
			nxt_s.scheme = cbd_scheme_t'(s_ff.sch_s2);
			nxt_s.bypass = !s_ff.comp_s2
				|| (cbd_scheme_t'(s_ff.sch_s2) == boundary_scan_scheme);
			nxt_s.edge_cnt = 3'h0;
			nxt_s.bit_cnt = 3'h0;
			nxt_s.shreg = `CBD_WORD_RST;
		end else if (cclk_rise) begin
			if (s_ff.edge_cnt == `CBD_PP_CLKS_PER_WORD - 3'h1) begin
				nxt_s.edge_cnt = 3'h0;
			end else begin
				nxt_s.edge_cnt = s_ff.edge_cnt + 3'h1;
			end
			nxt_s.shreg = ser_word;
			nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
		end
		// A word landing in the clearing cycle still counts
		nxt_s.overrun = (s_ff.overrun && s_ff.act_s2) || (s_ff.word_vld && exp_busy);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign overrun = s_ff.overrun;

	// ****************************************************************
	// Expander
	// ****************************************************************
	cbd_expander u_expander (
		.mclk(mclk),
		.rst(rst),
		.restart(!s_ff.act_s2),
		.bypass(s_ff.bypass),
		.in_valid(s_ff.word_vld),
		.in_data(s_ff.word),
		.out_valid(cell_wr_valid),
		.out_data(cell_wr_data),
		.busy(exp_busy)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_bypass_passthru;
		@(posedge mclk) disable iff (rst)
		(s_ff.word_vld && s_ff.bypass && s_ff.act_s2)
		|=> cell_wr_valid && cell_wr_data == $past(s_ff.word);
	endproperty
	a_bypass_passthru: assert property (p_bypass_passthru) else $error("bypass word altered");

	property p_scan_uncompressed;
		@(posedge mclk) disable iff (rst)
		(s_ff.act_s2 && s_ff.scheme == boundary_scan_scheme) |-> s_ff.bypass;
	endproperty
	a_scan_uncompressed: assert property (p_scan_uncompressed) else $error("scan path expanded");

	property p_own_setting;
		@(posedge mclk) disable iff (rst)
		(!s_ff.act_s2 && s_ff.comp_s2 && s_ff.sch_s2 != 2'b11) |=> !s_ff.bypass;
	endproperty
	a_own_setting: assert property (p_own_setting) else $error("setting not honoured");

	sequence s_pp_hold;
		cclk_rise && !word_take;
	endsequence

	property p_pp_four;
		@(posedge mclk) disable iff (rst)
		(word_take && s_ff.scheme == parallel_passive_scheme && !s_ff.bypass)
		|-> ##[1:300] s_pp_hold;
	endproperty
	a_pp_four: assert property (p_pp_four) else $error("compressed word taken twice");

	property p_no_overrun;
		@(posedge mclk) disable iff (rst)
		s_ff.word_vld |-> !exp_busy;
	endproperty
	a_no_overrun: assert property (p_no_overrun) else $error("expander throttled link");

	// ****************************************************************
	// Frame and strobe checks
	// ****************************************************************
	// A frozen mode is what keeps a chained device deaf to its neighbours' straps
	sequence s_in_frame;
		s_ff.act_s2 && $past(s_ff.act_s2);
	endsequence

	property p_mode_frozen;
		@(posedge mclk) disable iff (rst)
		s_in_frame |-> $stable(s_ff.scheme) && $stable(s_ff.bypass);
	endproperty
	a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed in frame");

	property p_plain_setting;
		@(posedge mclk) disable iff (rst)
		(!s_ff.act_s2 && !s_ff.comp_s2) |=> s_ff.bypass;
	endproperty
	a_plain_setting: assert property (p_plain_setting) else $error("plain setting lost");

	property p_pp_first_edge;
		@(posedge mclk) disable iff (rst)
		(word_take && s_ff.scheme == parallel_passive_scheme && !s_ff.bypass)
		|-> s_ff.edge_cnt == 3'h0 ##1 s_ff.edge_cnt == 3'h1;
	endproperty
	a_pp_first_edge: assert property (p_pp_first_edge) else $error("word not on first edge");

	property p_serial_eighth;
		@(posedge mclk) disable iff (rst)
		(word_take && s_ff.scheme != parallel_passive_scheme) |-> s_ff.bit_cnt == 3'h7;
	endproperty
	a_serial_eighth: assert property (p_serial_eighth) else $error("serial word short");

	property p_idle_no_take;
		@(posedge mclk) disable iff (rst)
		!s_ff.act_s2 |-> !word_take;
	endproperty
	a_idle_no_take: assert property (p_idle_no_take) else $error("word taken out of frame");

	property p_restart_quiet;
		@(posedge mclk) disable iff (rst)
		!s_ff.act_s2 |=> !cell_wr_valid;
	endproperty
	a_restart_quiet: assert property (p_restart_quiet) else $error("cell write out of frame");

	// A rise needs the second stage high and the third stage low, so a word strobe never lasts two cycles
	property p_strobe_single;
		@(posedge mclk) disable iff (rst)
		s_ff.word_vld |=> !s_ff.word_vld;
	endproperty
	a_strobe_single: assert property (p_strobe_single) else $error("word strobe too long");

	sequence s_word_in_run;
		s_ff.word_vld && exp_busy;
	endsequence

	property p_overrun_set;
		@(posedge mclk) disable iff (rst)
		s_word_in_run |=> overrun;
	endproperty
	a_overrun_set: assert property (p_overrun_set) else $error("overrun not raised");

	property p_overrun_hold;
		@(posedge mclk) disable iff (rst)
		(overrun && s_ff.act_s2) |=> overrun;
	endproperty
	a_overrun_hold: assert property (p_overrun_hold) else $error("overrun dropped in frame");

	property p_overrun_clear;
		@(posedge mclk) disable iff (rst)
		(!s_ff.act_s2 && !(s_ff.word_vld && exp_busy)) |=> !overrun;
	endproperty
	a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared");

endmodule : cbd_top

// ===== verif/cbd_host.sv
// Host model that drives the configuration link pins
module cbd_host (
	input wire logic mclk, // System clock that paces the link
	output logic config_clock, // Link clock, still low between words
	output logic serial_data, // Serial data, LSB first
	output logic [7:0] parallel_data // Parallel word
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		config_clock = 1'b0;
		serial_data = 1'b0;
		parallel_data = 8'h00;
	end
	// ****************************************************************
	// Link cycles, 160 ns each
	// ****************************************************************
	task automatic tick(input int n);
		repeat (n) begin
			repeat (4) @(posedge mclk);
			config_clock <= 1'b1;
			repeat (4) @(posedge mclk);
			config_clock <= 1'b0;
		end
	endtask : tick
	// Word held for n link clocks, four in compressed rows, one in the reset test
	task automatic send_par(input logic [7:0] w, input int n);
		// One edge after the previous release, so no pin is set twice in a step
		@(posedge mclk);
		parallel_data <= w;
		tick(n);
		// Released pins must not keep showing the old word
		parallel_data <= ~w;
	endtask : send_par
	task automatic send_ser(input logic [7:0] w);
		int i;
		@(posedge mclk);
		for (i = 0; i < 8; i++) begin
			serial_data <= w[i];
			tick(1);
		end
		serial_data <= ~w[7];
	endtask : send_ser
endmodule : cbd_host

// ===== verif/cbd_top_tb.sv
// Self-checking bench for the configuration bitstream decompressor
module cbd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cbd_pkg::*;
	typedef struct packed {
		cbd_scheme_t sch;
		logic comp;
		logic flip;
		logic [2:0] n;
		logic [0:3][7:0] b;
	} cbd_row_t;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic config_clock;
	logic serial_data;
	logic [7:0] parallel_data;
	logic [1:0] scheme_sel = 2'b00;
	logic compress_en = 1'b0;
	logic config_active = 1'b0;
	logic cell_wr_valid;
	logic overrun;
	logic [7:0] cell_wr_data;
	logic [7:0] got[$];
	int err_total = 0;
	int compares = 0;
	int r;
	// ****************************************************************
	// Frames: scheme, compression, flip mid-frame, word count, words
	// ****************************************************************
	cbd_row_t rows[6] = '{
		'{parallel_passive_scheme, 1'b0, 1'b1, 3'h2, 32'ha53c0000},
		'{active_serial_scheme, 1'b0, 1'b0, 3'h1, 32'h3c000000},
		'{passive_serial_scheme, 1'b1, 1'b0, 3'h3, 32'h015a6600},
		'{active_serial_scheme, 1'b1, 1'b0, 3'h1, 32'h81000000},
		'{parallel_passive_scheme, 1'b1, 1'b0, 3'h3, 32'h8f007700},
		'{boundary_scan_scheme, 1'b1, 1'b0, 3'h2, 32'h81010000}
	};
	cbd_top i_cbd_top (.mclk(mclk), .rst(rst), .config_clock(config_clock),
		.serial_data(serial_data), .parallel_data(parallel_data), .scheme_sel(scheme_sel),
		.compress_en(compress_en), .config_active(config_active),
		.cell_wr_valid(cell_wr_valid), .cell_wr_data(cell_wr_data), .overrun(overrun));
	cbd_host i_cbd_host (.mclk(mclk), .config_clock(config_clock),
		.serial_data(serial_data), .parallel_data(parallel_data));
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		if (cell_wr_valid === 1'b1) begin
			got.push_back(cell_wr_data);
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check
	// Boundary-scan frames never expand, whatever the setting
	function automatic void expand(input cbd_row_t w, ref logic [7:0] q[$]);
		int i;
		int k;
		i = 0;
		q = {};
		while (i < w.n) begin
			if (!w.comp || w.sch == boundary_scan_scheme) begin
				q.push_back(w.b[i]);
				i++;
			end else if (w.b[i][7]) begin
				repeat ({1'b0, w.b[i][3:0]} + 5'h1) q.push_back(8'h00);
				i++;
			end else begin
				k = w.b[i][6:0] + 1;
				i++;
				while (k > 0 && i < w.n) begin
					q.push_back(w.b[i]);
					i++;
					k--;
				end
			end
		end
	endfunction : expand
	task automatic run_row(input cbd_row_t w);
		int i;
		logic [7:0] q[$];
		expand(w, q);
		@(posedge mclk);
		scheme_sel <= w.sch;
		compress_en <= w.comp;
		config_active <= 1'b0;
		repeat (6) @(posedge mclk);
		got = {};
		config_active <= 1'b1;
		repeat (4) @(posedge mclk);
		// The compression pin changes in mid-frame on flip rows and must be ignored
		if (w.flip) compress_en <= ~w.comp;
		for (i = 0; i < w.n; i++) begin
			// Whole frame is one kind of data
			if (w.sch == parallel_passive_scheme) i_cbd_host.send_par(w.b[i], w.comp ? 4 : 1);
			else i_cbd_host.send_ser(w.b[i]);
		end
		repeat (40) @(posedge mclk);
		check("count", 32'(got.size()), 32'(q.size()));
		foreach (q[j]) check("data", got[j], q[j]);
		check("overrun", overrun, 1'b0);
		config_active <= 1'b0;
	endtask : run_row
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		repeat (16) @(posedge mclk);
		check("rst_valid", cell_wr_valid, 1'b0);
		check("rst_overrun", overrun, 1'b0);
		rst <= 1'b0;
		for (r = 0; r < 6; r++) begin
			run_row(rows[r]);
			$display("row %0d done", r);
		end
		// Reset lands just after the first fill word of a sixteen-word zero run
		@(posedge mclk);
		scheme_sel <= 2'b10;
		compress_en <= 1'b1;
		repeat (6) @(posedge mclk);
		config_active <= 1'b1;
		repeat (4) @(posedge mclk);
		i_cbd_host.send_par(8'h8f, 1);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		check("mid_valid", cell_wr_valid, 1'b0);
		check("mid_data", cell_wr_data, 8'h00);
		rst <= 1'b0;
		config_active <= 1'b0;
		// A compressed frame shows the expander is back at a token after the cut run
		run_row(rows[3]);
		$display("reset test done");
		report_and_stop();
	end
	initial begin
		#1000000;
		err_total++;
		$display("BAD watchdog expected done seen hang");
		report_and_stop();
	end
endmodule : cbd_top_tb
